//--- logic/i2c_spike_filter.sv
// Spike filter and start/stop detector for a two-wire target port.
// Assumes scl/sda pins are asynchronous; filtered lines and events are handed to link_clk.
`timescale 1ns/1ps
// Operation
// - Sample bus lines with system clock
// - Flag more than two spikes per 600ns
// - Fast mode sampling clock 8 to 40MHz (package sets 50MHz, so rate_ok_ff stays low)
// - Slow clock may misread data as low
// - Slow clock may miss start condition
// - Fast clock may detect false start/stop
// - Reject pulses up to 50ns wide
// - Feed target in standard and fast modes
module i2c_spike_filter (
    // Sampling clock domain
    input  wire logic                               sys_clk,
    input  wire logic                               reset,
    // Target interface clock domain
    input  wire logic                               link_clk,
    // Bus pins
    input  wire logic                               scl_pin,
    input  wire logic                               sda_pin,
    // Filtered bus and events, link_clk domain
    output i2c_spike_filter_pkg::bus_lines_s        bus_ff,
    output i2c_spike_filter_pkg::bus_events_s       event_ff,
    // Sampling clock inside specified range, sys_clk domain
    output logic                                    rate_ok_ff
);

    localparam int WW = $clog2(i2c_spike_filter_pkg::DENSITY_CYCLES + 1);
    localparam logic [WW-1:0] WINDOW =
        WW'(i2c_spike_filter_pkg::DENSITY_CYCLES);
    localparam int PERIOD = i2c_spike_filter_pkg::SYS_PERIOD_NS;
    localparam logic RATE_OK =
        (i2c_spike_filter_pkg::SYS_CLK_MHZ >=
         i2c_spike_filter_pkg::SCK_MIN_MHZ) &&
        (i2c_spike_filter_pkg::SYS_CLK_MHZ <=
         i2c_spike_filter_pkg::SCK_MAX_MHZ);

    logic [1:0]                         pins;
    logic [1:0]                         filt;
    logic [1:0]                         spike;
    i2c_spike_filter_pkg::bus_lines_s   prev_ff;
    logic                               start_tgl_ff;
    logic                               stop_tgl_ff;
    logic                               ovl_tgl_ff;
    logic [WW-1:0]                      age0_ff;
    logic [WW-1:0]                      age1_ff;
    logic                               ovl_evt;

    assign pins = {scl_pin, sda_pin};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_line
            line_glitch_filter #(
                .STABLE (i2c_spike_filter_pkg::STABLE_CYCLES)
            ) u_filt (
                .sys_clk  (sys_clk),
                .reset    (reset),
                .line_pin (pins[g]),
                .filt_ff  (filt[g]),
                .spike_ff (spike[g])
            );
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rate_ok_ff <= 1'h0;
        end else begin
            rate_ok_ff <= RATE_OK;
        end
    end

    // start and stop seen on filtered lines
    // Fast clocks pass spike pairs around scl fall as conditions
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            prev_ff      <= '{scl: 1'h1, sda: 1'h1};
            start_tgl_ff <= 1'h0;
            stop_tgl_ff  <= 1'h0;
        end else begin
            prev_ff <= '{scl: filt[1], sda: filt[0]};
            if (filt[1] && prev_ff.scl && prev_ff.sda && !filt[0]) begin
                start_tgl_ff <= !start_tgl_ff;
            end
            if (filt[1] && prev_ff.scl && !prev_ff.sda && filt[0]) begin
                stop_tgl_ff <= !stop_tgl_ff;
            end
        end
    end

    // third spike inside window is an overload
    // A pair in one cycle needs only one earlier spike in the window
    assign ovl_evt = ((spike != 2'h0) && (age1_ff < WINDOW)) ||
                     ((spike == 2'h3) && (age0_ff < WINDOW));

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            age0_ff    <= WINDOW;
            age1_ff    <= WINDOW;
            ovl_tgl_ff <= 1'h0;
        end else begin
            if (spike == 2'h3) begin
                // Both lines at once count as two spikes
                age1_ff <= '0;
                age0_ff <= '0;
            end else if (spike != 2'h0) begin
                age1_ff <= (age0_ff < WINDOW) ? age0_ff + WW'(1) : WINDOW;
                age0_ff <= '0;
            end else begin
                age0_ff <= (age0_ff < WINDOW) ? age0_ff + WW'(1) : WINDOW;
                age1_ff <= (age1_ff < WINDOW) ? age1_ff + WW'(1) : WINDOW;
            end
            if (ovl_evt) begin
                ovl_tgl_ff <= !ovl_tgl_ff;
            end
        end
    end

    // Link domain. Reset is a level, so it crosses on two flops.
    logic       lrst_meta_ff;
    logic       lrst_ff;
    logic [1:0] lvl_meta_ff;
    logic [1:0] lvl_ff;
    logic [2:0] tgl_meta_ff;
    logic [2:0] tgl_ff;
    logic [2:0] tgl_old_ff;

    always_ff @(posedge link_clk) begin
        lrst_meta_ff <= reset;
        lrst_ff      <= lrst_meta_ff;
    end

    // levels and event toggles cross on two flops
    always_ff @(posedge link_clk) begin
        if (lrst_ff) begin
            lvl_meta_ff <= 2'h3;
            lvl_ff      <= 2'h3;
            tgl_meta_ff <= 3'h0;
            tgl_ff      <= 3'h0;
            tgl_old_ff  <= 3'h0;
        end else begin
            lvl_meta_ff <= filt;
            lvl_ff      <= lvl_meta_ff;
            tgl_meta_ff <= {start_tgl_ff, stop_tgl_ff, ovl_tgl_ff};
            tgl_ff      <= tgl_meta_ff;
            tgl_old_ff  <= tgl_ff;
        end
    end

    // filtered bus and one-cycle events to the target
    always_ff @(posedge link_clk) begin
        if (lrst_ff) begin
            bus_ff   <= '{scl: 1'h1, sda: 1'h1};
            event_ff <= '0;
        end else begin
            bus_ff   <= '{scl: lvl_ff[1], sda: lvl_ff[0]};
            event_ff <= '{start:    tgl_ff[2] ^ tgl_old_ff[2],
                          stop:     tgl_ff[1] ^ tgl_old_ff[1],
                          overload: tgl_ff[0] ^ tgl_old_ff[0]};
        end
    end

    a_start_detect: assert property (
        @(posedge sys_clk) disable iff (reset)
        (prev_ff.scl && filt[1] && $fell(filt[0])) |=> $changed(start_tgl_ff)
    ) else $error("start condition not recorded");

    a_stop_detect: assert property (
        @(posedge sys_clk) disable iff (reset)
        (prev_ff.scl && filt[1] && $rose(filt[0])) |=> $changed(stop_tgl_ff)
    ) else $error("stop condition not recorded");

    a_no_start_low: assert property (
        @(posedge sys_clk) disable iff (reset)
        $changed(start_tgl_ff) |-> $past(filt[1]) && !$past(filt[0])
    ) else $error("start recorded with scl low");

    a_density_flag: assert property (
        @(posedge sys_clk) disable iff (reset)
        (spike != 2'h0 && age1_ff < WINDOW) |=> $changed(ovl_tgl_ff)
    ) else $error("spike overload missed");

    a_density_pair: assert property (
        @(posedge sys_clk) disable iff (reset)
        (spike == 2'h3 && age0_ff < WINDOW) |=> $changed(ovl_tgl_ff)
    ) else $error("spike pair overload missed");

    a_density_quiet: assert property (
        @(posedge sys_clk) disable iff (reset)
        (spike == 2'h0) |=> $stable(ovl_tgl_ff)
    ) else $error("overload without a spike");

    a_rate_flag: assert property (
        @(posedge sys_clk) disable iff (reset)
        ##1 rate_ok_ff ==
            (PERIOD >= 1000 / i2c_spike_filter_pkg::SCK_MAX_MHZ &&
             PERIOD <= 1000 / i2c_spike_filter_pkg::SCK_MIN_MHZ)
    ) else $error("rate flag wrong");

    a_event_pulse: assert property (
        @(posedge link_clk) disable iff (lrst_ff)
        event_ff.start |=> !event_ff.start
    ) else $error("start pulse longer than one cycle");

    a_link_follow: assert property (
        @(posedge link_clk) disable iff (lrst_ff)
        $changed(tgl_ff[2]) |=> event_ff.start
    ) else $error("start toggle not delivered");

    c_start: cover property (
        @(posedge link_clk) disable iff (lrst_ff) event_ff.start
    );
    c_stop: cover property (
        @(posedge link_clk) disable iff (lrst_ff) event_ff.stop
    );
    c_overload: cover property (
        @(posedge link_clk) disable iff (lrst_ff) event_ff.overload
    );
    c_spike_pair: cover property (
        @(posedge sys_clk) disable iff (reset) spike == 2'h3
    );

endmodule

//--- logic/i2c_spike_filter_pkg.sv
// Constants and carriers for the two-wire input spike filter.
// Assumes a 50 MHz sampling clock; link side logic runs on its own clock.
package i2c_spike_filter_pkg;

    // Sampling clock
    localparam int SYS_CLK_MHZ       = 50;
    localparam int SYS_PERIOD_NS     = 1000 / SYS_CLK_MHZ;

    // Spike width rejected in fast mode, ns, and as a longest time in cycles
    localparam int SPIKE_WIDTH_NS    = 50;
    localparam int SPIKE_CYCLES      = (SPIKE_WIDTH_NS * SYS_CLK_MHZ) / 1000;
    // A spike can cover one edge more than its whole periods, so a level
    // is accepted only after one edge more than that
    localparam int STABLE_CYCLES     = SPIKE_CYCLES + 2;

    // Spike density limit: at most this many spikes per window
    localparam int DENSITY_WINDOW_NS = 600;
    localparam int DENSITY_CYCLES    =
        (DENSITY_WINDOW_NS * SYS_CLK_MHZ) / 1000;
    localparam int MAX_SPIKES        = 2;

    // Sampling clock range that the filter is specified for, MHz
    localparam int SCK_MIN_MHZ       = 8;
    localparam int SCK_MAX_MHZ       = 40;
    // Sampling periods, ns, at which known misreads become possible
    localparam int SLOW_PERIOD_NS    = 120;
    localparam int FAST_PERIOD_NS    = 50;
    localparam int HOLD_PERIODS      = 5;

    // Line reset value and synchroniser depth
    localparam logic LINE_IDLE       = 1'h1;
    localparam int   SYNC_STAGES     = 2;

    typedef struct packed {
        logic scl;
        logic sda;
    } bus_lines_s;

    typedef struct packed {
        logic start;
        logic stop;
        logic overload;
    } bus_events_s;

endpackage

//--- logic/line_glitch_filter.sv
// One bus line: two-stage synchroniser followed by a stability filter.
// Assumes the line is asynchronous to sys_clk and idles high.
`timescale 1ns/1ps
module line_glitch_filter #(
    parameter int STABLE = i2c_spike_filter_pkg::STABLE_CYCLES
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic reset,
    // Line in
    input  wire logic line_pin,
    // Filtered line and rejected spike
    output logic      filt_ff,
    output logic      spike_ff
);

    localparam int CW = $clog2(STABLE + 1);
    localparam logic [CW-1:0] LAST = CW'(STABLE - 1);

    logic          meta_ff;
    logic          samp_ff;
    logic [CW-1:0] cnt_ff;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            meta_ff <= i2c_spike_filter_pkg::LINE_IDLE;
            samp_ff <= i2c_spike_filter_pkg::LINE_IDLE;
        end else begin
            meta_ff <= line_pin;
            samp_ff <= meta_ff;
        end
    end

    // slow clocks widen the window, hence the misreads
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            filt_ff  <= i2c_spike_filter_pkg::LINE_IDLE;
            cnt_ff   <= '0;
            spike_ff <= 1'h0;
        end else begin
            spike_ff <= 1'h0;
            if (samp_ff != filt_ff) begin
                if (cnt_ff == LAST) begin
                    filt_ff <= samp_ff;
                    cnt_ff  <= '0;
                end else begin
                    cnt_ff <= cnt_ff + CW'(1);
                end
            end else if (cnt_ff != '0) begin
                // Returned before acceptance: a spike
                spike_ff <= 1'h1;
                cnt_ff   <= '0;
            end
        end
    end

    a_accept_stable: assert property (
        @(posedge sys_clk) disable iff (reset)
        !$stable(filt_ff) |-> $past(cnt_ff) == LAST
    ) else $error("line accepted before stable time");

    a_spike_short: assert property (
        @(posedge sys_clk) disable iff (reset)
        spike_ff |-> $past(cnt_ff) != '0 && $stable(filt_ff)
    ) else $error("spike flagged without a pending change");

    a_accept_value: assert property (
        @(posedge sys_clk) disable iff (reset)
        !$stable(filt_ff) |-> filt_ff == $past(samp_ff, 1)
    ) else $error("accepted level differs from sample");

    c_spike_seen: cover property (
        @(posedge sys_clk) disable iff (reset) spike_ff
    );

endmodule

//--- verif/bus_master_model.sv
// Behavioural bus controller driving the clock and data pins.
// Assumes pins idle high and changes are paced by sys_clk falling edges.
`timescale 1ns/1ps
module bus_master_model #(
    parameter int SPIKE_NS = 45
) (
    // Pacing clock
    input  wire logic sys_clk,
    // Bus pins
    output logic      scl_pin,
    output logic      sda_pin
);
    initial begin
        scl_pin = 1'h1;
        sda_pin = 1'h1;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // start: data falls while clock high
    task automatic start_cond();
        sda_pin = 1'h0;
        wait_cyc(40);
        scl_pin = 1'h0;
        wait_cyc(40);
    endtask

    // stop: data rises while clock high
    task automatic stop_cond();
        sda_pin = 1'h0;
        wait_cyc(20);
        scl_pin = 1'h1;
        wait_cyc(40);
        sda_pin = 1'h1;
        wait_cyc(40);
    endtask

    // data only changes while clock low
    task automatic send_bit(input logic b);
        sda_pin = b;
        wait_cyc(20);
        scl_pin = 1'h1;
        wait_cyc(40);
        scl_pin = 1'h0;
        wait_cyc(20);
    endtask

    // short inversions; width stays under the 50ns limit
    task automatic spike_scl();
        scl_pin = ~scl_pin;
        #(SPIKE_NS);
        scl_pin = ~scl_pin;
    endtask

    task automatic spike_sda();
        sda_pin = ~sda_pin;
        #(SPIKE_NS);
        sda_pin = ~sda_pin;
    endtask

    // both lines in one sample count as two spikes
    task automatic spike_both();
        scl_pin = ~scl_pin;
        sda_pin = ~sda_pin;
        #(SPIKE_NS);
        scl_pin = ~scl_pin;
        sda_pin = ~sda_pin;
    endtask
endmodule

//--- verif/testbench.sv
// Self-checking bench for the two-wire spike filter.
// Assumes a free-running link clock and the bus master model as driver.
`timescale 1ns/1ps
module testbench;
    logic                              sys_clk;
    logic                              link_clk;
    logic                              reset;
    logic                              scl_pin;
    logic                              sda_pin;
    i2c_spike_filter_pkg::bus_lines_s  bus_ff;
    i2c_spike_filter_pkg::bus_events_s event_ff;
    logic                              rate_ok_ff;
    int                                n_mismatch;
    int                                check_count;
    int                                n_start;
    int                                n_stop;
    int                                n_ovl;
    int                                cyc;

    i2c_spike_filter uut (
        .sys_clk    (sys_clk),
        .reset      (reset),
        .link_clk   (link_clk),
        .scl_pin    (scl_pin),
        .sda_pin    (sda_pin),
        .bus_ff     (bus_ff),
        .event_ff   (event_ff),
        .rate_ok_ff (rate_ok_ff)
    );

    bus_master_model mst (
        .sys_clk (sys_clk),
        .scl_pin (scl_pin),
        .sda_pin (sda_pin)
    );

    initial sys_clk = 1'h0;
    always #10 sys_clk = ~sys_clk;
    // Odd start offset keeps the link clock out of phase
    initial begin
        link_clk = 1'h0;
        #3;
        forever #7.5 link_clk = ~link_clk;
    end

    // Event pulses last one link cycle, so count them here
    always @(posedge link_clk) begin
        if (event_ff.start === 1'h1) n_start++;
        if (event_ff.stop === 1'h1) n_stop++;
        if (event_ff.overload === 1'h1) n_ovl++;
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Hang guard: whole run needs well under 3000 cycles
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 6000) begin
            n_mismatch++;
            end_sim();
        end
    end

    task automatic t_idle();
        check("rate_ok", {31'h0, rate_ok_ff}, 32'h0);
        check("bus idle", {30'h0, bus_ff}, 32'h3);
        check("no events", n_start + n_stop + n_ovl, 32'h0);
    endtask

    // Two spikes per window are dropped without an overload
    task automatic t_sparse();
        mst.spike_scl();
        mst.wait_cyc(20);
        mst.spike_sda();
        mst.wait_cyc(60);
        check("bus after spikes", {30'h0, bus_ff}, 32'h3);
        check("events sparse", n_start + n_stop, 32'h0);
        check("overload sparse", n_ovl, 32'h0);
    endtask

    // Third spike inside 600ns raises one overload
    task automatic t_dense();
        mst.spike_sda();
        mst.wait_cyc(5);
        mst.spike_scl();
        mst.wait_cyc(5);
        mst.spike_sda();
        mst.wait_cyc(60);
        check("overload dense", n_ovl, 32'h1);
        check("bus dense", {30'h0, bus_ff}, 32'h3);
    endtask

    // One spike, then a pair in one sample, raises one more overload
    task automatic t_pair();
        mst.spike_sda();
        mst.wait_cyc(5);
        mst.spike_both();
        mst.wait_cyc(60);
        check("overload pair", n_ovl, 32'h2);
        check("bus pair", {30'h0, bus_ff}, 32'h3);
    endtask

    task automatic t_start_data();
        mst.start_cond();
        check("start count", n_start, 32'h1);
        check("bus after start", {30'h0, bus_ff}, 32'h0);
        mst.send_bit(1'h1);
        check("bit one", {30'h0, bus_ff}, 32'h1);
        mst.send_bit(1'h0);
        check("bit zero", {30'h0, bus_ff}, 32'h0);
    endtask

    // Data spike while clock high must not look like start or stop
    task automatic t_hi_spike();
        mst.sda_pin = 1'h1;
        mst.wait_cyc(20);
        mst.scl_pin = 1'h1;
        mst.wait_cyc(10);
        mst.spike_sda();
        mst.wait_cyc(40);
        check("bus clock high", {30'h0, bus_ff}, 32'h3);
        check("no false start", n_start, 32'h1);
        check("no false stop", n_stop, 32'h0);
        mst.scl_pin = 1'h0;
        mst.wait_cyc(40);
    endtask

    task automatic t_stop();
        mst.stop_cond();
        check("stop count", n_stop, 32'h1);
        check("bus after stop", {30'h0, bus_ff}, 32'h3);
        check("overload total", n_ovl, 32'h2);
    endtask

    initial begin
        reset = 1'h1;
        n_mismatch = 0;
        check_count = 0;
        n_start = 0;
        n_stop = 0;
        n_ovl = 0;
        cyc = 0;
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        reset = 1'h0;
        mst.wait_cyc(20);
        t_idle();
        t_sparse();
        t_dense();
        t_pair();
        t_start_data();
        t_hi_spike();
        t_stop();
        end_sim();
    end
endmodule
